// ---- core/debug_event_sequencer.sv ----
// Debug event sequencer: channel combination, measurement, branch trace, link
//
// What this block does
// - Sequential break halts only after channels three, two, one (or two, one) match in order.
// - Entering a combination mode disables involved channels until re-enabled.
// - A match on a delay-slot instruction is taken before the branch target.
// - A power-on reset in the matching cycle leaves every channel unsatisfied.
// - Sequence order follows bus-cycle order of matches, not program order.
// - Run-time reconfiguration suspends the core for up to 52 bus clocks.
// - While reconfiguring, all channel conditions are disabled.
// - A transfer-controller collision on external bus may drop a match.
// - Trace keeps the four latest branches with source and destination.
// - Single stepping disables software and channel breaks.
// - The core may run two or more instructions after a match.
// - Point-to-point window opens on the start channel, closes on the other.
// - Without point-to-point, the window spans run time until break.
// - Four measurement counters run independently and at once.
// - Each counter is 32 bits, read whole, with overflow indication.
// - Branch counting adds two per taken branch.
// - A recurring start reopens the window and accumulates the count.
`timescale 1ns/1ps
`include "dbg_cfg.svh"
module debug_event_sequencer
    import dbg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Core events
    input core_evt_t core_evt,
    input branch_rec_t branch_rec,
    input wire logic por_pulse,
    input wire logic dtc_collide,
    // Emulator link
    input wire logic link_clk,
    input wire logic link_sel,
    input wire logic link_din,
    output logic link_dout,
    // Core control
    output logic break_req,
    output logic cpu_suspend,
    output logic meas_window
);
    link_evt_t lk;
    logic [`DBG_CFG_W-1:0] shift_in_ff;
    logic [`DBG_RD_W-1:0] shift_out_ff;
    logic link_dout_ff;
    combo_mode_t mode_ff;
    logic [3:0] ch_en_ff;
    logic [2:0] item_ff [`DBG_CH_N];
    logic [2:0] rd_sel_ff;
    logic step_ff;
    logic [5:0] susp_cnt_ff;
    seq_state_t seq_ff;
    seq_state_t nxt_seq;
    logic [1:0] gap_ff;
    logic break_ff;
    logic window_ff;
    logic nxt_window;
    logic [`DBG_CNT_W-1:0] cnt_ff [`DBG_CH_N];
    logic ovf_ff [`DBG_CH_N];
    branch_rec_t trace_ff [`DBG_TRACE_N];

    link_sync u_link_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .link_clk(link_clk),
        .link_sel(link_sel),
        .link_din(link_din),
        .evt(lk)
    );

    // Decode of the committed word
    wire commit = lk.sel_fall;
    wire combo_mode_t new_mode = combo_mode_t'(shift_in_ff[`DBG_CFG_MODE_LSB +: 3]);
    wire [3:0] new_en = shift_in_ff[`DBG_CFG_EN_LSB +: 4];
    wire cnt_init = commit & shift_in_ff[`DBG_CFG_INIT_BIT];

    function automatic logic [3:0] involved(input combo_mode_t m);
        case (m)
            MODE_SEQ_321: involved = 4'h7;
            MODE_SEQ_21: involved = 4'h3;
            MODE_PA_21: involved = 4'h3;
            MODE_PA_12: involved = 4'h3;
            default: involved = 4'h0;
        endcase
    endfunction

    wire [3:0] commit_en = (new_mode != mode_ff) ? (new_en & ~involved(new_mode)) : new_en;

    wire suspending = (susp_cnt_ff != 6'h0);
    wire match_gate = ~por_pulse & ~suspending & ~dtc_collide;
    wire [3:0] hit = core_evt.ch_match & ch_en_ff & {4{match_gate}};
    wire gap_ok = (gap_ff >= 2'(`DBG_GAP_INSN));
    wire is_seq = (mode_ff == MODE_SEQ_321) || (mode_ff == MODE_SEQ_21);
    wire is_pa = (mode_ff == MODE_PA_21) || (mode_ff == MODE_PA_12);

    always_comb begin
        nxt_seq = seq_ff;
        case (seq_ff)
            SQ_IDLE: begin
                if (mode_ff == MODE_SEQ_321 && hit[2]) begin
                    nxt_seq = SQ_GOT_THREE;
                end else if (mode_ff == MODE_SEQ_21 && hit[1]) begin
                    nxt_seq = SQ_GOT_TWO;
                end
            end
            SQ_GOT_THREE: begin
                if (hit[1] && gap_ok) begin
                    nxt_seq = SQ_GOT_TWO;
                end
            end
            SQ_GOT_TWO: begin
                if (hit[0] && gap_ok) begin
                    nxt_seq = SQ_IDLE;
                end
            end
            default: nxt_seq = SQ_IDLE;
        endcase
        if (!is_seq || commit) begin
            nxt_seq = SQ_IDLE;
        end
    end

    wire stage_adv = (nxt_seq != seq_ff) && is_seq && !commit;
    wire seq_fire = is_seq && (seq_ff == SQ_GOT_TWO) && hit[0] && gap_ok;
    wire [3:0] direct_ch = ch_en_ff & ~involved(mode_ff);
    // Slot match breaks at once, before the target
    wire nxt_break = ~step_ff & (seq_fire | (|(hit & direct_ch)));

    // Start and end channels per mode
    wire pa_start = (mode_ff == MODE_PA_21) ? hit[1] : hit[0];
    wire pa_end = (mode_ff == MODE_PA_21) ? hit[0] : hit[1];
    always_comb begin
        nxt_window = window_ff;
        if (is_pa) begin
            if (pa_start) begin
                nxt_window = 1'b1;
            end else if (pa_end) begin
                nxt_window = 1'b0;
            end
        end else begin
            nxt_window = core_evt.running & ~break_ff;
        end
        if (por_pulse) begin
            nxt_window = 1'b0;
        end
    end

    // Readback selection
    wire [`DBG_RD_W-1:0] rd_word = rd_sel_ff[2] ?
        {1'b0, trace_ff[rd_sel_ff[1:0]]} :
        {ovf_ff[rd_sel_ff[1:0]], 32'h0, cnt_ff[rd_sel_ff[1:0]]};

    // Link shifting and configuration
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            shift_in_ff <= '0;
            shift_out_ff <= '0;
            link_dout_ff <= 1'b0;
        end else if (lk.sel_rise) begin
            shift_out_ff <= rd_word;
        end else if (lk.sel && lk.clk_rise) begin
            shift_in_ff <= {lk.din, shift_in_ff[`DBG_CFG_W-1:1]};
            link_dout_ff <= shift_out_ff[0];
            shift_out_ff <= {1'b0, shift_out_ff[`DBG_RD_W-1:1]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mode_ff <= combo_mode_t'(`DBG_MODE_RST);
            ch_en_ff <= `DBG_EN_RST;
            rd_sel_ff <= 3'h0;
            step_ff <= 1'b0;
            susp_cnt_ff <= 6'h0;
        end else if (commit) begin
            mode_ff <= new_mode;
            ch_en_ff <= commit_en;
            rd_sel_ff <= shift_in_ff[`DBG_CFG_RDSEL_LSB +: 3];
            step_ff <= shift_in_ff[`DBG_CFG_STEP_BIT];
            // Hold the core while settings change
            susp_cnt_ff <= core_evt.running ? 6'(`DBG_SUSPEND_CYC) : 6'h0;
        end else if (suspending) begin
            susp_cnt_ff <= susp_cnt_ff - 6'h1;
        end
    end

    generate
        for (genvar i = 0; i < `DBG_CH_N; i++) begin : g_item
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    item_ff[i] <= 3'h0;
                end else if (commit) begin
                    item_ff[i] <= shift_in_ff[`DBG_CFG_ITEM_LSB + 3*i +: 3];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            seq_ff <= SQ_IDLE;
            gap_ff <= 2'h0;
            break_ff <= 1'b0;
            window_ff <= 1'b0;
        end else begin
            seq_ff <= nxt_seq;
            if (stage_adv) begin
                gap_ff <= 2'h0;
            end else if (core_evt.insn_done && !gap_ok) begin
                gap_ff <= gap_ff + 2'h1;
            end
            // Core halts at its own pace
            break_ff <= nxt_break;
            window_ff <= nxt_window;
        end
    end

    generate
        for (genvar i = 0; i < `DBG_CH_N; i++) begin : g_cnt
            logic [1:0] inc;
            logic [`DBG_CNT_W:0] sum;
            always_comb begin
                case (meas_item_t'(item_ff[i]))
                    ITEM_ELAPSED: inc = {1'b0, core_evt.clk_run};
                    ITEM_EXEC_STATES: inc = {1'b0, core_evt.clk_run & ~core_evt.stall};
                    ITEM_BRANCH: inc = core_evt.branch_taken ? 2'(`DBG_BRANCH_INC) : 2'h0;
                    ITEM_INSN: inc = {1'b0, core_evt.insn_done};
                    ITEM_EXCEPTION: inc = {1'b0, core_evt.exception};
                    ITEM_IRQ: inc = {1'b0, core_evt.irq};
                    default: inc = 2'h0;
                endcase
                if (!window_ff) begin
                    inc = 2'h0;
                end
                sum = {1'b0, cnt_ff[i]} + {31'h0, inc};
            end
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    cnt_ff[i] <= '0;
                    ovf_ff[i] <= 1'b0;
                end else if (cnt_init) begin
                    cnt_ff[i] <= '0;
                    ovf_ff[i] <= sum[`DBG_CNT_W];
                end else begin
                    cnt_ff[i] <= sum[`DBG_CNT_W-1:0];
                    ovf_ff[i] <= ovf_ff[i] | sum[`DBG_CNT_W];
                end
            end
        end
    endgenerate

    generate
        for (genvar i = 0; i < `DBG_TRACE_N; i++) begin : g_trace
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    trace_ff[i] <= '0;
                end else if (core_evt.branch_taken) begin
                    trace_ff[i] <= (i == 0) ? branch_rec : trace_ff[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    assign link_dout = link_dout_ff;
    assign break_req = break_ff;
    assign meas_window = window_ff;

    logic susp_out_ff;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            susp_out_ff <= 1'b0;
        end else begin
            susp_out_ff <= commit ? core_evt.running : (susp_cnt_ff > 6'h1);
        end
    end
    assign cpu_suspend = susp_out_ff;
endmodule // debug_event_sequencer

// ---- core/dbg_cfg.svh ----
// Constants for the debug event sequencer: field positions, widths, timing counts
`ifndef DBG_CFG_SVH
`define DBG_CFG_SVH

// Configuration word shifted in over the link, LSB first
`define DBG_CFG_W 24
`define DBG_CFG_MODE_LSB 0
`define DBG_CFG_EN_LSB 3
`define DBG_CFG_ITEM_LSB 7
`define DBG_CFG_RDSEL_LSB 19
`define DBG_CFG_INIT_BIT 22
`define DBG_CFG_STEP_BIT 23

// Readback word: overflow or zero, then 64 data bits
`define DBG_RD_W 65

// Widths and counts
`define DBG_CH_N 4
`define DBG_CNT_W 32
`define DBG_TRACE_N 4
`define DBG_ADDR_W 32

// Run-time reconfiguration holds the core for this many bus clocks
`define DBG_SUSPEND_CYC 52
// Least instruction spacing between two sequence stages
`define DBG_GAP_INSN 2
// Counter step for each taken branch
`define DBG_BRANCH_INC 2

// Reset values
`define DBG_EN_RST 4'h0
`define DBG_MODE_RST 3'h0

`endif

// ---- core/dbg_pkg.sv ----
// Types shared by the debug event sequencer files
package dbg_pkg;

    // Combination modes of channels one to three
    typedef enum logic [2:0] {
        MODE_NONE = 3'h0,
        MODE_SEQ_321 = 3'h1,
        MODE_SEQ_21 = 3'h2,
        MODE_PA_21 = 3'h3,
        MODE_PA_12 = 3'h4
    } combo_mode_t;

    // Measurement items of one performance counter
    typedef enum logic [2:0] {
        ITEM_OFF = 3'h0,
        ITEM_ELAPSED = 3'h1,
        ITEM_EXEC_STATES = 3'h2,
        ITEM_BRANCH = 3'h3,
        ITEM_INSN = 3'h4,
        ITEM_EXCEPTION = 3'h5,
        ITEM_IRQ = 3'h6
    } meas_item_t;

    // Sequence progress, one bit changes from idle to three and from three to two
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_GOT_THREE = 2'b01,
        SQ_GOT_TWO = 2'b11
    } seq_state_t;

    // Per-cycle events from the core, same clock
    typedef struct packed {
        logic [3:0] ch_match;
        logic insn_done;
        logic branch_taken;
        logic exception;
        logic irq;
        logic clk_run;
        logic stall;
        logic running;
    } core_evt_t;

    // One branch record
    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
    } branch_rec_t;

    // Link pins after synchronisation
    typedef struct packed {
        logic clk_rise;
        logic sel_rise;
        logic sel_fall;
        logic sel;
        logic din;
    } link_evt_t;

endpackage

// ---- core/link_sync.sv ----
// Two-stage synchroniser and edge finder for the emulator link pins
`timescale 1ns/1ps
`include "dbg_cfg.svh"
module link_sync
    import dbg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Raw link pins
    input wire logic link_clk,
    input wire logic link_sel,
    input wire logic link_din,
    // Synchronised events
    output link_evt_t evt
);
    logic [2:0] meta_ff;
    logic [2:0] sync_ff;
    logic [1:0] last_ff;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            meta_ff <= 3'h0;
            sync_ff <= 3'h0;
            last_ff <= 2'h0;
        end else begin
            meta_ff <= {link_din, link_sel, link_clk};
            sync_ff <= meta_ff;
            last_ff <= sync_ff[1:0];
        end
    end

    assign evt.clk_rise = sync_ff[0] & ~last_ff[0];
    assign evt.sel_rise = sync_ff[1] & ~last_ff[1];
    assign evt.sel_fall = ~sync_ff[1] & last_ff[1];
    assign evt.sel = sync_ff[1];
    assign evt.din = sync_ff[2];
endmodule // link_sync

// ---- test/debug_event_sequencer_properties.sv ----
// Port checks on the debug event sequencer
`timescale 1ns/1ps
module debug_event_sequencer_props
    import dbg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Core side inputs
    input core_evt_t core_evt,
    input branch_rec_t branch_rec,
    input wire logic por_pulse,
    input wire logic dtc_collide,
    // Link pins
    input wire logic link_clk,
    input wire logic link_sel,
    input wire logic link_din,
    input wire logic link_dout,
    // Core control
    input wire logic break_req,
    input wire logic cpu_suspend,
    input wire logic meas_window
);
    logic [7:0] susp_ff;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Length of the current hold
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !cpu_suspend) begin
            susp_ff <= 8'h0;
        end else begin
            susp_ff <= susp_ff + 8'h1;
        end
    end

    chk_por_blocks: assert property (por_pulse |=> !break_req)
        else $error("break after power-on match");
    chk_dtc_blocks: assert property (dtc_collide |=> !break_req)
        else $error("break after collision match");
    chk_susp_blocks: assert property (cpu_suspend |=> !break_req)
        else $error("break during hold");
    chk_susp_len: assert property ($fell(cpu_suspend) |-> susp_ff == 8'h34)
        else $error("hold length wrong");
    chk_susp_cause: assert property ($rose(cpu_suspend) |-> $past(core_evt.running))
        else $error("hold while core idle");
    chk_break_cause: assert property (break_req |-> $past(core_evt.ch_match) != 4'h0)
        else $error("break without match");
    chk_window_rise: assert property ($rose(meas_window) |->
        $past(core_evt.ch_match) != 4'h0 || $past(core_evt.running))
        else $error("window opened without cause");
    chk_dout_quiet: assert property ((!link_sel)[*8] |=> $stable(link_dout))
        else $error("readback moved outside frame");

    cover property ($rose(cpu_suspend));
    cover property (break_req);
    cover property ($fell(meas_window));
endmodule // debug_event_sequencer_props

bind debug_event_sequencer debug_event_sequencer_props debug_event_sequencer_props_i (
    .ref_clk, .reset_n, .core_evt, .branch_rec, .por_pulse, .dtc_collide,
    .link_clk, .link_sel, .link_din, .link_dout,
    .break_req, .cpu_suspend, .meas_window
);

// ---- test/link_probe.sv ----
// Emulator probe model driving the serial link
`timescale 1ns/1ps
module link_probe (
    // Link pins
    output logic link_clk,
    output logic link_sel,
    output logic link_din,
    input wire logic link_dout
);
    localparam realtime HALF = 62.5;

    initial begin
        link_clk = 1'b0;
        link_sel = 1'b0;
        link_din = 1'b0;
    end

    // frames carry no breakpoint commands
    // Padding first, word last, one readback bit per clock
    task automatic frame(input logic [23:0] w, output logic [64:0] rd);
        logic [64:0] s;
        s = {w, 41'h0};
        link_sel = 1'b1;
        #(HALF);
        for (int i = 0; i < 65; i++) begin
            link_din = s[i];
            #(HALF);
            link_clk = 1'b1;
            #(HALF);
            link_clk = 1'b0;
            rd[i] = link_dout;
        end
        #(HALF);
        link_sel = 1'b0;
        // Released line shows the inverse
        link_din = ~s[64];
        // Select stays low long enough to commit
        #(4*HALF);
    endtask
endmodule // link_probe

// ---- test/tb_debug_event_sequencer.sv ----
// Self-checking bench for the debug event sequencer
`timescale 1ns/1ps
`include "dbg_cfg.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin failures++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module tb_debug_event_sequencer
    import dbg_pkg::*;
    ;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic por = 1'b0;
    logic data_transfer_controller = 1'b0;
    core_evt_t ev = '0;
    branch_rec_t br = '0;
    logic link_clk, link_sel, link_din, link_dout;
    logic break_req, cpu_suspend, meas_window;
    logic [64:0] rd;
    int failures = 0;
    int n_compared = 0;
    int brk = 0;
    int sus = 0;
    int nb = 0;

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        brk <= brk + int'(break_req === 1'b1);
        sus <= sus + int'(cpu_suspend === 1'b1);
    end

    debug_event_sequencer debug_event_sequencer_i (
        .ref_clk, .reset_n, .core_evt(ev), .branch_rec(br), .por_pulse(por),
        .dtc_collide(data_transfer_controller), .link_clk, .link_sel, .link_din, .link_dout,
        .break_req, .cpu_suspend, .meas_window
    );
    link_probe link_probe_i (.link_clk, .link_sel, .link_din, .link_dout);

    function automatic logic [23:0] word(input logic [2:0] md, input logic [3:0] en,
        input logic [11:0] it = 12'h0, input logic [2:0] rs = 3'h0,
        input logic [1:0] fl = 2'h0);
        return {fl, rs, it, en, md};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic cfg(input logic [23:0] w);
        link_probe_i.frame(w, rd);
        cyc(8);
    endtask

    // One match cycle, then n instruction completions
    task automatic pulse(input logic [3:0] m, input int n = 0,
        input logic p = 1'b0, input logic d = 1'b0);
        ev.ch_match <= m;
        por <= p;
        data_transfer_controller <= d;
        cyc(1);
        ev.ch_match <= 4'h0;
        por <= 1'b0;
        data_transfer_controller <= 1'b0;
        repeat (n) begin
            ev.insn_done <= 1'b1;
            cyc(1);
            ev.insn_done <= 1'b0;
            cyc(1);
        end
        cyc(3);
    endtask

    // Taken branches with numbered records
    task automatic evt(input int n);
        repeat (n) begin
            nb++;
            ev.branch_taken <= 1'b1;
            ev.insn_done <= 1'b1;
            br <= {32'h100 + 32'(nb), 32'h200 + 32'(nb)};
            cyc(1);
        end
        ev.branch_taken <= 1'b0;
        ev.insn_done <= 1'b0;
        cyc(2);
    endtask

    task automatic sc_mask;
        int b0;
        int s0;
        cfg(word(3'h0, 4'h8));
        b0 = brk;
        pulse(4'h8, 0, 1'b1, 1'b0);
        pulse(4'h8, 0, 1'b0, 1'b1);
        `CHK("masked match", 0, brk - b0)
        pulse(4'h8);
        `CHK("direct break", 1, brk - b0)
        // step mode suppresses the channel four break
        cfg(word(3'h0, 4'h8, 12'h0, 3'h0, 2'h2));
        pulse(4'h8);
        `CHK("step break", 1, brk - b0)
        s0 = sus;
        ev.running <= 1'b1;
        cfg(word(3'h0, 4'h8));
        pulse(4'h8);
        cyc(60);
        `CHK("held match", 1, brk - b0)
        `CHK("hold cycles", `DBG_SUSPEND_CYC, sus - s0)
        `CHK("run window", 1'b1, meas_window)
        ev.running <= 1'b0;
        cyc(3);
        `CHK("idle window", 1'b0, meas_window)
    endtask

    task automatic sc_seq;
        int b0;
        cfg(word(3'h1, 4'h7));
        cfg(word(3'h1, 4'h7));
        b0 = brk;
        pulse(4'h1, 2);
        pulse(4'h4, 2);
        pulse(4'h2, 2);
        `CHK("seq partial", 0, brk - b0)
        pulse(4'h1);
        `CHK("seq break", 1, brk - b0)
        pulse(4'h4);
        pulse(4'h2, 2);
        pulse(4'h1);
        `CHK("seq too close", 1, brk - b0)
        cfg(word(3'h2, 4'h3));
        cfg(word(3'h2, 4'h3));
        pulse(4'h2, 2);
        pulse(4'h1);
        `CHK("two stage break", 2, brk - b0)
    endtask

    task automatic sc_meas;
        cfg(word(3'h3, 4'h3, 12'hd63, 3'h0, 2'h1));
        pulse(4'h2);
        `CHK("mode drops enable", 1'b0, meas_window)
        cfg(word(3'h3, 4'h3, 12'hd63));
        pulse(4'h2);
        `CHK("window open", 1'b1, meas_window)
        evt(3);
        pulse(4'h1);
        `CHK("window shut", 1'b0, meas_window)
        evt(1);
        pulse(4'h2);
        evt(1);
        pulse(4'h1);
        link_probe_i.frame(word(3'h3, 4'h3, 12'hd63, 3'h1), rd);
        `CHK("branch count", {33'h0, 32'h8}, rd)
        link_probe_i.frame(word(3'h3, 4'h3, 12'hd63, 3'h4), rd);
        `CHK("insn count", {33'h0, 32'h4}, rd)
        link_probe_i.frame(word(3'h3, 4'h3, 12'hd63, 3'h7), rd);
        `CHK("newest branch", {1'b0, 32'h105, 32'h205}, rd)
        link_probe_i.frame(word(3'h3, 4'h3, 12'hd63), rd);
        `CHK("oldest branch", {1'b0, 32'h102, 32'h202}, rd)
        cfg(word(3'h4, 4'h3));
        cfg(word(3'h4, 4'h3));
        pulse(4'h1);
        `CHK("reverse open", 1'b1, meas_window)
        pulse(4'h2);
        `CHK("reverse shut", 1'b0, meas_window)
    endtask

    task automatic conclude;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        cyc(4);
        sc_mask();
        sc_seq();
        sc_meas();
        conclude();
    end
endmodule // tb_debug_event_sequencer
